// *** design/bos_defs.vh ***
// Constants for the burst output sequencer: register map, fields, counts
`ifndef BOS_DEFS_VH
`define BOS_DEFS_VH

// Register byte offsets
`define BOS_OFS_CTRL 8'h00
`define BOS_OFS_NEXP 8'h34
`define BOS_OFS_STAT 8'h40

// Control register fields
`define BOS_CTRL_FILT 14
`define BOS_CTRL_RATE 5
`define BOS_CTRL_AUTO 2
`define BOS_CTRL_RST 32'h00000000

// Burst exponent field: code in bits 13..10, exponent is code plus base
`define BOS_NEXP_HI 13
`define BOS_NEXP_LO 10
`define BOS_NEXP_RST 4'h0
`define BOS_NEXP_BASE 5'h0A

// Sequence figures
`define BOS_INIT_EXP 5'h0D
`define BOS_LOCK_ADD 5'h03
`define BOS_TRIG_DLY 2'h2
`define BOS_SYNC_INVAL 6'h24
`define BOS_DEC_FACTOR 2'h3

// Sequencer states
`define BOS_ST_IDLE 3'h0
`define BOS_ST_INIT 3'h1
`define BOS_ST_ARMED 3'h2
`define BOS_ST_DELAY 3'h3
`define BOS_ST_HIGH_RESOLUTION_FLAG 3'h4
`define BOS_ST_LOCK 3'h5

`endif

// *** design/bos_sequencer.v ***
// Burst output sequencer with APB control registers and sync marker
`timescale 1ns/10ps
`include "bos_defs.vh"

module bos_sequencer #(
    parameter DATA_W = 12,
    parameter CNT_W = 29
) (
    input wire pclk, // Sample clock
    input wire presetn, // Asynchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error for unmapped address
    input wire [DATA_W-1:0] sample_a, // Channel A converter sample
    input wire [DATA_W-1:0] sample_b, // Channel B converter sample
    input wire burst_request_pair, // Burst request pin
    input wire sync_in, // Sync pin
    output reg [DATA_W-1:0] channel_a_output_bus, // Channel A data
    output reg [DATA_W-1:0] channel_b_output_bus, // Channel B data
    output reg channel_a_marker, // Marker bit on bus A
    output reg channel_b_marker, // Marker bit on bus B
    output reg [1:0] forwarded_output_clocks, // DDR output clocks A,B
    output reg sync_marker_out, // Sync marker
    output reg trigger_ready_flag, // Burst may be requested
    output reg high_resolution_flag // High-res sample on bus
);

    // Control registers and sequencer state
    reg [31:0] ctrl;
    reg [3:0] nexp_code;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [CNT_W-1:0] cnt;
    reg [4:0] n_active;
    reg [1:0] dly_cnt;
    reg filt_prev;
    // Three-stage pin synchronisers and their settled levels
    reg trig_s1;
    reg trig_s2;
    reg trig_s3;
    reg trig_lvl;
    reg sync_s1;
    reg sync_s2;
    reg sync_s3;
    reg sync_lvl;
    // Sync, invalid window, marker and clock stretch
    reg sync_done;
    reg [5:0] inval_cnt;
    reg [4:0] mark_cnt;
    reg mark_run;
    reg stretch;
    reg [1:0] dec_cnt;
    // Decimated samples held for four outputs
    reg [10:0] held_a;
    reg [10:0] held_b;

    // Decoded control bits
    wire filt_sel = ctrl[`BOS_CTRL_FILT];
    wire rate_sel = ctrl[`BOS_CTRL_RATE];
    wire auto_sel = ctrl[`BOS_CTRL_AUTO];
    // Access completes when ready is seen with select and enable
    wire apb_acc = psel & penable & pready;
    wire apb_wr = apb_acc & pwrite;
    // Exponent is the stored code plus ten, so it stays in range
    wire [4:0] n_prog = `BOS_NEXP_BASE + {1'b0, nexp_code};
    // Rising edges count once stages two and three agree
    wire trig_rise = (trig_s2 == trig_s3) & trig_s3 & ~trig_lvl;
    wire sync_rise = (sync_s2 == sync_s3) & sync_s3 & ~sync_lvl;
    // Only the first sync edge acts until the next reset
    wire sync_hit = sync_rise & ~sync_done;
    // Leaving filter mode starts a fresh initial stretch
    wire enable_evt = filt_prev & ~filt_sel;
    // Last count of each stretch, derived from the exponent
    wire [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};
    wire [CNT_W-1:0] init_last = (one << `BOS_INIT_EXP) - one;
    wire [CNT_W-1:0] high_resolution_flag_last = (one << n_active) - one;
    wire [CNT_W-1:0] lock_last = (one << (n_active + `BOS_LOCK_ADD)) - one;

    // Pin synchronisers for trigger and sync, three stages each
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            trig_lvl <= 1'b0;
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
            sync_lvl <= 1'b0;
        end else begin
            // Pins pass two flops before any logic reads them
            trig_s1 <= burst_request_pair;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            sync_s1 <= sync_in;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
            // Level follows the pin only once two stages agree
            if (trig_s2 == trig_s3) begin
                trig_lvl <= trig_s3;
            end
            if (sync_s2 == sync_s3) begin
                sync_lvl <= sync_s3;
            end
        end
    end

    // APB register writes and handshake
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `BOS_CTRL_RST;
            nexp_code <= `BOS_NEXP_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            // Seen as set so burst mode opens with an initial stretch
            filt_prev <= 1'b1;
        end else begin
            filt_prev <= filt_sel;
            // One wait state: ready answers the first access cycle
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
                case (paddr)
                    `BOS_OFS_CTRL: begin
                        prdata <= ctrl;
                    end
                    `BOS_OFS_NEXP: begin
                        prdata[`BOS_NEXP_HI:`BOS_NEXP_LO] <= nexp_code;
                    end
                    `BOS_OFS_STAT: begin
                        // Status word: N, sync seen, flags, spare, state
                        prdata <= {20'h00000, n_active, sync_done,
                            high_resolution_flag, trigger_ready_flag,
                            1'b0, state};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
            // Writes land on the edge that completes the access
            if (apb_wr) begin
                case (paddr)
                    `BOS_OFS_CTRL: begin
                        // Only the defined control bits are kept
                        ctrl <= pwdata & ((32'h00000001 << `BOS_CTRL_FILT)
                            | (32'h00000001 << `BOS_CTRL_RATE)
                            | (32'h00000001 << `BOS_CTRL_AUTO));
                    end
                    `BOS_OFS_NEXP: begin
                        nexp_code <= pwdata[`BOS_NEXP_HI:`BOS_NEXP_LO];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Next-state logic of the burst sequence
    always @* begin
        next_state = state;
        // Each stretch ends when its counter reaches the last count
        case (state)
            `BOS_ST_IDLE: begin
                next_state = `BOS_ST_INIT;
            end
            `BOS_ST_INIT: begin
                if (cnt == init_last) begin
                    next_state = auto_sel ? `BOS_ST_HIGH_RESOLUTION_FLAG
                        : `BOS_ST_ARMED;
                end
            end
            `BOS_ST_ARMED: begin
                if (auto_sel) begin
                    next_state = `BOS_ST_HIGH_RESOLUTION_FLAG;
                end else if (trig_rise) begin
                    next_state = `BOS_ST_DELAY;
                end
            end
            `BOS_ST_DELAY: begin
                if (dly_cnt == `BOS_TRIG_DLY - 2'h1) begin
                    next_state = `BOS_ST_HIGH_RESOLUTION_FLAG;
                end
            end
            `BOS_ST_HIGH_RESOLUTION_FLAG: begin
                if (cnt == high_resolution_flag_last) begin
                    next_state = `BOS_ST_LOCK;
                end
            end
            `BOS_ST_LOCK: begin
                if (cnt == lock_last) begin
                    next_state = auto_sel ? `BOS_ST_HIGH_RESOLUTION_FLAG
                        : `BOS_ST_ARMED;
                end
            end
            default: begin
                next_state = `BOS_ST_IDLE;
            end
        endcase
        // Mode select and restart events override the sequence
        if (filt_sel) begin
            next_state = `BOS_ST_IDLE;
        end else if (enable_evt || sync_hit) begin
            next_state = `BOS_ST_INIT;
        end
    end

    // Sequencer state, sample counter and exponent latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= `BOS_ST_IDLE;
            cnt <= {CNT_W{1'b0}};
            dly_cnt <= 2'h0;
            // Exponent starts at its reset value of ten
            n_active <= `BOS_NEXP_BASE;
        end else begin
            state <= next_state;
            // Delay counter runs only while a burst start is pending
            dly_cnt <= (next_state == `BOS_ST_DELAY) ? dly_cnt + 2'h1 : 2'h0;
            // Counter restarts on every state change
            if (next_state != state) begin
                cnt <= {CNT_W{1'b0}};
            end else begin
                cnt <= cnt + one;
            end
            // Exponent taken when a burst starts and again when lockout starts
            if (next_state == `BOS_ST_HIGH_RESOLUTION_FLAG && state != `BOS_ST_HIGH_RESOLUTION_FLAG) begin
                n_active <= n_prog;
            end else if (state == `BOS_ST_HIGH_RESOLUTION_FLAG
                && next_state == `BOS_ST_LOCK) begin
                n_active <= n_prog;
            end
        end
    end

    // Sync handling, invalid window and output clock with stretch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_done <= 1'b0;
            inval_cnt <= 6'h00;
            forwarded_output_clocks <= 2'b00;
            stretch <= 1'b0;
            mark_cnt <= 5'h00;
            mark_run <= 1'b0;
        end else begin
            // First sync edge opens the invalid output window
            if (sync_hit) begin
                sync_done <= 1'b1;
                inval_cnt <= `BOS_SYNC_INVAL;
            end else if (inval_cnt != 6'h00) begin
                inval_cnt <= inval_cnt - 6'h01;
            end
            // Sync on the falling-edge sample holds the clock high two
            // extra samples so the marker lines up with a rising edge
            stretch <= sync_hit & forwarded_output_clocks[0];
            if (!(sync_hit & forwarded_output_clocks[0]) && !stretch) begin
                // Output clock toggles every sample, double data rate
                forwarded_output_clocks <= ~forwarded_output_clocks;
            end
            // Free 5-bit marker counter, restarted on next rising edge
            if (sync_hit) begin
                mark_run <= 1'b0;
            end else if (!mark_run && sync_done
                && !forwarded_output_clocks[0] && !stretch) begin
                mark_run <= 1'b1;
                mark_cnt <= 5'h00;
            end else begin
                mark_cnt <= mark_cnt + 5'h01;
            end
        end
    end

    // Output data, flags and markers, one register stage in all modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_a_output_bus <= {DATA_W{1'b0}};
            channel_b_output_bus <= {DATA_W{1'b0}};
            channel_a_marker <= 1'b0;
            channel_b_marker <= 1'b0;
            sync_marker_out <= 1'b0;
            trigger_ready_flag <= 1'b0;
            high_resolution_flag <= 1'b0;
            dec_cnt <= 2'h0;
            held_a <= 11'h000;
            held_b <= 11'h000;
        end else begin
            // Marker pulses when the free counter wraps to zero
            sync_marker_out <= mark_run & (mark_cnt == 5'h00);
            channel_a_marker <= mark_run & (mark_cnt == 5'h00);
            channel_b_marker <= mark_run & (mark_cnt == 5'h00);
            // Flag registered with the data so both line up
            high_resolution_flag <= (state == `BOS_ST_HIGH_RESOLUTION_FLAG);
            // Ready: level in manual mode, one-cycle pulse in auto
            if (state == `BOS_ST_IDLE) begin
                trigger_ready_flag <= 1'b0;
            end else if (auto_sel) begin
                trigger_ready_flag <= (state == `BOS_ST_HIGH_RESOLUTION_FLAG)
                    && (cnt == {CNT_W{1'b0}});
            end else begin
                trigger_ready_flag <= (state == `BOS_ST_ARMED);
            end
            // Decimation phase, realigned by the first sync
            dec_cnt <= (dec_cnt == `BOS_DEC_FACTOR || sync_hit)
                ? 2'h0 : dec_cnt + 2'h1;
            // Keep one sample in four for the repeated outputs
            if (dec_cnt == 2'h0) begin
                held_a <= sample_a[DATA_W-1:DATA_W-11];
                held_b <= sample_b[DATA_W-1:DATA_W-11];
            end
            // Invalid window first, then full samples in idle or high-res, 9-bit or 11-bit
            if (inval_cnt != 6'h00) begin
                channel_a_output_bus <= {DATA_W{1'b0}};
                channel_b_output_bus <= {DATA_W{1'b0}};
            end else if (state == `BOS_ST_IDLE
                || state == `BOS_ST_HIGH_RESOLUTION_FLAG) begin
                channel_a_output_bus <= sample_a;
                channel_b_output_bus <= sample_b;
            end else if (!rate_sel) begin
                channel_a_output_bus <= {sample_a[DATA_W-1:DATA_W-9],
                    3'b000};
                channel_b_output_bus <= {sample_b[DATA_W-1:DATA_W-9],
                    3'b000};
            end else if (dec_cnt == 2'h0) begin
                channel_a_output_bus <= {sample_a[DATA_W-1:DATA_W-11],
                    1'b0};
                channel_b_output_bus <= {sample_b[DATA_W-1:DATA_W-11],
                    1'b0};
            end else begin
                channel_a_output_bus <= {held_a, 1'b0};
                channel_b_output_bus <= {held_b, 1'b0};
            end
        end
    end

endmodule

// *** sim/bos_checker.sv ***
// Port assertions for the burst output sequencer
`timescale 1ns/10ps
module bos_checker (
    input wire pclk, // Sample clock
    input wire presetn, // Reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire pready, // APB ready
    input wire burst_request_pair, // Trigger pin
    input wire [11:0] channel_a_output_bus, // Bus A
    input wire [11:0] channel_b_output_bus, // Bus B
    input wire channel_a_marker, // Marker on bus A
    input wire channel_b_marker, // Marker on bus B
    input wire sync_in, // Sync pin
    input wire sync_marker_out, // Sync marker
    input wire trigger_ready_flag, // Ready flag
    input wire high_resolution_flag // High-res flag
);
    reg [31:0] ctl;
    reg [10:0] hcnt;
    reg [13:0] lcnt;
    reg [7:0] sgap;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of control writes, run lengths and time since sync
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 32'h0;
            hcnt <= 11'h0;
            lcnt <= 14'h0;
            sgap <= 8'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 8'h00)
                ctl <= pwdata;
            hcnt <= high_resolution_flag ? hcnt + 11'h1 : 11'h0;
            if (high_resolution_flag)
                lcnt <= 14'h0;
            else if (lcnt != 14'h3FFF)
                lcnt <= lcnt + 14'h1;
            if (sync_in)
                sgap <= 8'h0;
            else if (sgap != 8'hFF)
                sgap <= sgap + 8'h1;
        end
    end
    property p_high_resolution_flag_len;
        $fell(high_resolution_flag) && !ctl[14] |-> hcnt == 11'h400;
    endproperty
    property p_lock_quiet;
        $fell(high_resolution_flag) |-> !trigger_ready_flag [*8];
    endproperty
    property p_lock_len;
        $rose(trigger_ready_flag) && !high_resolution_flag && !ctl[2]
            |-> lcnt >= 14'h1FFE && lcnt <= 14'h2008;
    endproperty
    property p_auto_pulse;
        $rose(trigger_ready_flag) && ctl[2] |=> !trigger_ready_flag;
    endproperty
    property p_filt_idle;
        ctl[14] [*3] |-> !trigger_ready_flag && !high_resolution_flag;
    endproperty
    property p_nine_bit;
        (!high_resolution_flag && !ctl[5] && !ctl[14]) [*4]
            |-> channel_a_output_bus[2:0] == 3'h0
            && channel_b_output_bus[2:0] == 3'h0;
    endproperty
    property p_decim;
        (!high_resolution_flag && ctl[5] && !ctl[14]) [*4]
            |-> !channel_a_output_bus[0] && !channel_b_output_bus[0];
    endproperty
    property p_trig;
        $rose(burst_request_pair) && trigger_ready_flag && !ctl[2]
            && !ctl[14] |-> ##[4:9] high_resolution_flag;
    endproperty
    property p_marker_both;
        channel_a_marker == sync_marker_out
            && channel_b_marker == sync_marker_out;
    endproperty
    property p_marker_period;
        sgap == 8'hFF && sync_marker_out
            |=> !sync_marker_out [*8] ##24 sync_marker_out;
    endproperty
    a_high_resolution_flag_len: assert property (p_high_resolution_flag_len) else $error("burst length");
    a_lock_quiet: assert property (p_lock_quiet) else $error("ready early");
    a_lock_len: assert property (p_lock_len) else $error("lockout length");
    a_auto_pulse: assert property (p_auto_pulse) else $error("pulse wide");
    a_filt_idle: assert property (p_filt_idle) else $error("filter flags");
    a_nine_bit: assert property (p_nine_bit) else $error("9-bit lsbs");
    a_decim: assert property (p_decim) else $error("11-bit lsb");
    a_trig: assert property (p_trig) else $error("trigger delay");
    a_marker_both: assert property (p_marker_both) else $error("marker");
    a_marker_period: assert property (p_marker_period) else $error("gap");
    c_burst: cover property ($rose(high_resolution_flag));
    c_marker: cover property ($rose(sync_marker_out));
    c_filter: cover property (ctl[14] && !trigger_ready_flag);
endmodule
bind bos_sequencer bos_checker u_bos_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .burst_request_pair(burst_request_pair),
    .channel_a_output_bus(channel_a_output_bus),
    .channel_b_output_bus(channel_b_output_bus),
    .channel_a_marker(channel_a_marker), .channel_b_marker(channel_b_marker),
    .sync_in(sync_in), .sync_marker_out(sync_marker_out),
    .trigger_ready_flag(trigger_ready_flag),
    .high_resolution_flag(high_resolution_flag));

// *** sim/bos_partner.sv ***
// Capture-side model that drives the trigger and sync pins
`timescale 1ns/10ps
module bos_partner (
    input wire lclk, // Receiver clock
    input wire go, // Bench asks for a trigger level
    input wire sync_on, // Bench enables periodic sync
    output reg burst_request_pair, // Trigger pin
    output reg sync_in // Sync pin
);
    // Pins start low before the receiver clock runs
    initial begin
        burst_request_pair = 1'b0;
        sync_in = 1'b0;
    end
    // Trigger held a whole receiver cycle; sync period is 32 samples
    always @(posedge lclk) begin
        burst_request_pair <= go;
        sync_in <= sync_on & ~sync_in;
    end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the burst output sequencer
`timescale 1ns/10ps
`include "bos_defs.vh"
module tb;
    reg pclk, presetn, psel, penable, pwrite, lclk, go, sync_on, e, h;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd;
    reg [11:0] sample_a, sample_b, prev;
    wire [31:0] prdata;
    wire pready, pslverr, burst_request_pair, sync_in, sync_marker_out;
    wire [11:0] channel_a_output_bus, channel_b_output_bus;
    wire channel_a_marker, channel_b_marker;
    wire trigger_ready_flag, high_resolution_flag;
    integer err_total, checked, cyc, rel, n, k, j;
    reg [1:0] fprev;
    wire [1:0] fwd_clk;
    bos_sequencer u_bos_sequencer (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_a(sample_a), .sample_b(sample_b),
        .burst_request_pair(burst_request_pair), .sync_in(sync_in),
        .channel_a_output_bus(channel_a_output_bus),
        .channel_b_output_bus(channel_b_output_bus),
        .channel_a_marker(channel_a_marker),
        .channel_b_marker(channel_b_marker), .forwarded_output_clocks(fwd_clk),
        .sync_marker_out(sync_marker_out),
        .trigger_ready_flag(trigger_ready_flag),
        .high_resolution_flag(high_resolution_flag));
    bos_partner u_bos_partner (.lclk(lclk), .go(go), .sync_on(sync_on),
        .burst_request_pair(burst_request_pair), .sync_in(sync_in));
    // Sample clock and an unrelated receiver clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        lclk = 1'b0;
        #37;
        forever #80 lclk = ~lclk;
    end
    // Samples keep the top bit set so real data is never zero
    always @(posedge pclk) begin
        sample_a <= {1'b1, sample_a[10:0] + 11'h001};
        sample_b <= {1'b1, ~sample_a[10:0]};
        cyc = cyc + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        checked = checked + 1;
        if (got !== ex) begin
            err_total = err_total + 1;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Wait until a flag (0 ready, 1 high-res, 2 marker) reads v
    task wt(input integer s, input v, input integer lim);
        n = 0;
        h = 1'b0;
        while (n < lim && (s == 0 ? trigger_ready_flag : s == 1 ?
               high_resolution_flag : sync_marker_out) !== v) begin
            @(posedge pclk);
            n = n + 1;
            if (high_resolution_flag === 1'b1)
                h = 1'b1;
        end
    endtask
    task t_regs;
        apb(1'b0, `BOS_OFS_NEXP, 32'h0);
        chk("exp reset", 32'h0, rd);
        apb(1'b1, `BOS_OFS_NEXP, 32'h3C00);
        apb(1'b0, `BOS_OFS_NEXP, 32'h0);
        chk("exp max", 32'h3C00, rd);
        apb(1'b1, `BOS_OFS_NEXP, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b0, `BOS_OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
    endtask
    task t_manual;
        go <= 1'b1;
        repeat (40) @(posedge pclk);
        go <= 1'b0;
        wt(0, 1'b1, 9000);
        chk("init ignores", 32'h0, {31'h0, h});
        k = cyc - rel;
        chk("init len", 32'h1, {31'h0, k >= 8192 && k <= 8200});
        go <= 1'b1;
        wt(1, 1'b1, 60);
        chk("burst start", 32'h1, {31'h0, high_resolution_flag});
        go <= 1'b0;
        wt(1, 1'b0, 1100);
        chk("burst len", 32'h400, n);
        repeat (40) @(posedge pclk);
        go <= 1'b1;
        repeat (40) @(posedge pclk);
        go <= 1'b0;
        wt(0, 1'b1, 9000);
        chk("lock ignores", 32'h0, {31'h0, h});
        chk("lock len", 32'h1, {31'h0, n >= 8112 && n <= 8120});
    endtask
    task t_decim;
        apb(1'b1, `BOS_OFS_CTRL, 32'h20);
        repeat (8) @(posedge pclk);
        prev = channel_a_output_bus;
        fprev = fwd_clk;
        k = 0;
        j = 0;
        for (n = 0; n < 16; n = n + 1) begin
            @(posedge pclk);
            if (channel_a_output_bus !== prev)
                k = k + 1;
            if (fwd_clk !== ~fprev || fwd_clk[1] !== fwd_clk[0])
                j = j + 1;
            prev = channel_a_output_bus;
            fprev = fwd_clk;
        end
        chk("clock toggles", 32'h0, j);
        chk("decim steps", 32'h4, k);
        chk("decim lsb", 32'h0, {31'h0, prev[0]});
    endtask
    task t_mode;
        apb(1'b1, `BOS_OFS_CTRL, 32'h4);
        wt(1, 1'b1, 20000);
        chk("auto burst", 32'h1, {31'h0, high_resolution_flag});
        apb(1'b1, `BOS_OFS_CTRL, 32'h4000);
        repeat (6) @(posedge pclk);
        chk("flags", 32'h0, {trigger_ready_flag, high_resolution_flag});
        apb(1'b0, `BOS_OFS_STAT, 32'h0);
        chk("filter idle", 32'h0, rd[2:0]);
    endtask
    task t_sync;
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        sync_on <= 1'b1;
        n = 0;
        while (channel_a_output_bus !== 12'h000 && n < 200) begin
            @(posedge pclk);
            n = n + 1;
        end
        k = 0;
        while (channel_a_output_bus === 12'h000 && k < 100) begin
            @(posedge pclk);
            k = k + 1;
        end
        chk("sync gap", 32'h24, k);
        wt(2, 1'b1, 64);
        chk("marker", 32'h1, {31'h0, sync_marker_out});
        chk("marker b", 32'h1, {31'h0, channel_b_marker});
        sync_on <= 1'b0;
        repeat (400) @(posedge pclk);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, go, sync_on} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        sample_a = 12'h800;
        sample_b = 12'h800;
        {err_total, checked, cyc} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rel = cyc;
        t_regs;
        t_manual;
        t_decim;
        t_mode;
        t_sync;
        tally_and_finish;
    end
endmodule
